// ### inc/pch_pkg.sv
// Constants and carrier types for the configuration header register block
package pch_pkg;

    // ------------------------------------------------------------------
    // Register offsets in configuration space
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_MEM_BASE = 8'h10;
    localparam logic [7:0] OFS_IO_BASE = 8'h14;
    localparam logic [7:0] OFS_SUBSYS = 8'h2c;
    localparam logic [7:0] OFS_CAP_PTR = 8'h34;
    localparam logic [7:0] OFS_LAT_IRQ = 8'h3c;
    localparam logic [7:0] OFS_LIMITS = 8'h40;

    // ------------------------------------------------------------------
    // Values after reset
    // ------------------------------------------------------------------
    localparam logic [31:0] RST_MEM_BASE = 32'h0000_0000;
    localparam logic [31:0] RST_IO_BASE = 32'h0000_0001;
    localparam logic [31:0] RST_CAP_PTR = 32'h0000_0080;
    localparam logic [31:0] RST_LAT_IRQ = 32'h3e01_0100;
    localparam logic [31:0] RST_SUBSYS = 32'h0000_0000;
    localparam logic [7:0] RST_RETRY_LIMIT = 8'h00;
    localparam logic [7:0] RST_WAIT_LIMIT = 8'h00;

    // ------------------------------------------------------------------
    // Writable bit masks
    // ------------------------------------------------------------------
    localparam logic [31:0] WMASK_MEM_BASE = 32'hffff_ffff;
    localparam logic [31:0] WMASK_IO_BASE = 32'hffff_fffe;
    localparam logic [31:0] WMASK_LAT_IRQ = 32'h0000_00ff;

    // ------------------------------------------------------------------
    // Window sizes and field positions
    // ------------------------------------------------------------------
    localparam int MEM_WIN_BYTES = 4096;
    localparam int MEM_WIN_SHIFT = $clog2(MEM_WIN_BYTES);
    localparam int IO_WIN_BYTES = 256;
    localparam int IO_WIN_SHIFT = $clog2(IO_WIN_BYTES);
    localparam int SUBSYSTEM_IDENTIFIER_LSB = 16;
    localparam int RETRY_LSB = 8;
    localparam int LINE_LSB = 0;
    localparam int STRAP_SETTLE_CYCLES = 3;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic req;
        logic we;
        logic [7:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } pch_cfg_req_s;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
    } pch_cfg_rsp_s;

    typedef struct packed {
        logic valid;
        logic [31:0] addr;
    } pch_bus_addr_s;

    typedef enum logic [1:0] {
        ID_SETTLE,
        ID_EPROM,
        ID_DONE
    } pch_id_state_e;

endpackage : pch_pkg

// ### tb/pch_cfg_header_regs_tb.sv
// Self-checking bench for the configuration header register block
`timescale 1ns/1ps
module pch_cfg_header_regs_tb;
    localparam logic [7:0] RL = 8'h03;
    localparam logic [7:0] WL = 8'h02;
    logic clock;
    logic rst;
    pch_pkg::pch_cfg_req_s cfg_req;
    pch_pkg::pch_cfg_rsp_s cfg_rsp;
    pch_pkg::pch_bus_addr_s bus_addr;
    logic mem_space_en, io_space_en, mem_hit, io_hit;
    logic [31:0] id_strap_pins, eprom_id_word;
    logic eprom_fitted_pin, eprom_id_valid, id_loaded;
    logic mst_start, mst_retry, mst_wait_trdy, mst_trdy, mst_retry_abort, mst_trdy_timeout;
    int n_errors = 0;
    int num_checks = 0;
    integer seed;
    int i;
    logic [31:0] exp_q[$];
    logic [31:0] d, d2, mb, ib, ew;
    logic [7:0] ro_ofs [3];
    logic [31:0] ro_val [3];

    pch_cfg_header_regs #(.RETRY_LIMIT(RL), .WAIT_LIMIT(WL)) uut (
        .clock(clock), .rst(rst), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp),
        .bus_addr(bus_addr), .mem_space_en(mem_space_en), .io_space_en(io_space_en),
        .mem_hit(mem_hit), .io_hit(io_hit), .id_strap_pins(id_strap_pins),
        .eprom_fitted_pin(eprom_fitted_pin), .eprom_id_valid(eprom_id_valid),
        .eprom_id_word(eprom_id_word), .id_loaded(id_loaded), .mst_start(mst_start),
        .mst_retry(mst_retry), .mst_wait_trdy(mst_wait_trdy), .mst_trdy(mst_trdy),
        .mst_retry_abort(mst_retry_abort), .mst_trdy_timeout(mst_trdy_timeout));

    pch_host_model host (.clock(clock), .cfg_req(cfg_req));

    // ------------------------------------------------------------------
    // Clock, comparison and closing
    // ------------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task automatic check(input string what, input logic [31:0] e, input logic [31:0] s);
        num_checks++;
        if (s !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, e, s);
        end
    endtask : check

    task automatic final_report();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : final_report

    // Expected read data is queued at issue; the watcher pops it on each ack
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        host.access(1'b0, a, 4'hf, 32'h0);
    endtask : rd

    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] w);
        exp_q.push_back(32'h0);
        host.access(1'b1, a, be, w);
    endtask : wr

    always @(negedge clock) begin
        if (cfg_rsp.ack === 1'b1) begin
            if (exp_q.size() == 0) begin
                n_errors++;
                $display("ERROR cfg_rsp.ack expected 0 seen 1");
            end else begin
                check("cfg_rsp.rdata", exp_q.pop_front(), cfg_rsp.rdata);
            end
        end
    end

    task automatic hit_chk(input logic me, input logic ie, input logic v, input logic [31:0] a,
                           input logic em, input logic ei);
        #1 mem_space_en = me;
        io_space_en = ie;
        bus_addr = {v, a};
        @(posedge clock);
        @(negedge clock);
        check("mem_hit", {31'h0, em}, {31'h0, mem_hit});
        check("io_hit", {31'h0, ei}, {31'h0, io_hit});
        @(posedge clock);
    endtask : hit_chk

    initial begin
        repeat (5000) @(posedge clock);
        n_errors++;
        $display("ERROR watchdog expired");
        final_report();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        seed = 54;
        rst = 1'b1;
        bus_addr = '0;
        {mem_space_en, io_space_en, eprom_fitted_pin, eprom_id_valid} = 4'h0;
        {mst_start, mst_retry, mst_wait_trdy, mst_trdy} = 4'h0;
        id_strap_pins = $random(seed);
        eprom_id_word = 32'h0;
        repeat (4) @(posedge clock);
        #1 rst = 1'b0;
        @(posedge clock);
        rd(pch_pkg::OFS_MEM_BASE, 32'h0000_0000);
        rd(pch_pkg::OFS_IO_BASE, 32'h0000_0001);
        rd(pch_pkg::OFS_CAP_PTR, 32'h0000_0080);
        rd(pch_pkg::OFS_LAT_IRQ, 32'h3e01_0100);
        rd(pch_pkg::OFS_LIMITS, {16'h0000, RL, WL});
        rd(8'h18, 32'h0000_0000);
        host.idle(1);
        for (i = 0; i < 20 && id_loaded !== 1'b1; i++) @(posedge clock);
        check("id_loaded", 32'h1, {31'h0, id_loaded});
        rd(pch_pkg::OFS_SUBSYS, id_strap_pins);
        d = $random(seed);
        d2 = $random(seed);
        wr(pch_pkg::OFS_MEM_BASE, 4'hf, d);
        rd(pch_pkg::OFS_MEM_BASE, d);
        wr(pch_pkg::OFS_MEM_BASE, 4'h5, d2);
        rd(pch_pkg::OFS_MEM_BASE, {d[31:24], d2[23:16], d[15:8], d2[7:0]});
        wr(pch_pkg::OFS_IO_BASE, 4'hf, 32'h0);
        rd(pch_pkg::OFS_IO_BASE, 32'h0000_0001);
        ro_ofs = '{pch_pkg::OFS_SUBSYS, pch_pkg::OFS_CAP_PTR, pch_pkg::OFS_LIMITS};
        ro_val = '{id_strap_pins, 32'h0000_0080, {16'h0000, RL, WL}};
        for (i = 0; i < 3; i++) begin
            wr(ro_ofs[i], 4'hf, ~ro_val[i]);
            rd(ro_ofs[i], ro_val[i]);
        end
        wr(pch_pkg::OFS_LAT_IRQ, 4'hf, ~d);
        rd(pch_pkg::OFS_LAT_IRQ, {24'h3e0101, ~d[7:0]});
        wr(pch_pkg::OFS_LAT_IRQ, 4'he, d);
        rd(pch_pkg::OFS_LAT_IRQ, {24'h3e0101, ~d[7:0]});
        wr(8'h18, 4'hf, d);
        rd(8'h18, 32'h0000_0000);
        // Windows kept apart and away from the top so the boundary sums cannot wrap
        mb = {4'h4, d2[27:12], 12'h000};
        ib = {4'h8, d[27:8], 8'h00};
        wr(pch_pkg::OFS_MEM_BASE, 4'hf, mb);
        wr(pch_pkg::OFS_IO_BASE, 4'hf, ib);
        host.idle(2);
        hit_chk(1'b1, 1'b1, 1'b1, mb, 1'b1, 1'b0);
        hit_chk(1'b1, 1'b1, 1'b1, mb + 32'd4095, 1'b1, 1'b0);
        hit_chk(1'b1, 1'b1, 1'b1, mb + 32'd4096, 1'b0, 1'b0);
        hit_chk(1'b1, 1'b1, 1'b1, mb - 32'd1, 1'b0, 1'b0);
        hit_chk(1'b0, 1'b1, 1'b1, mb, 1'b0, 1'b0);
        hit_chk(1'b1, 1'b1, 1'b1, ib + 32'd255, 1'b0, 1'b1);
        hit_chk(1'b1, 1'b1, 1'b1, ib + 32'd256, 1'b0, 1'b0);
        hit_chk(1'b1, 1'b0, 1'b1, ib, 1'b0, 1'b0);
        hit_chk(1'b1, 1'b1, 1'b0, ib, 1'b0, 1'b0);
        #1 mst_start = 1'b1;
        @(posedge clock);
        #1 mst_start = 1'b0;
        mst_retry = 1'b1;
        for (i = 1; i <= RL + 1; i++) begin
            @(posedge clock);
            @(negedge clock);
            check("mst_retry_abort", {31'h0, i == RL + 1}, {31'h0, mst_retry_abort});
        end
        @(posedge clock);
        #1 mst_retry = 1'b0;
        mst_wait_trdy = 1'b1;
        for (i = 1; i <= WL + 1; i++) begin
            @(posedge clock);
            @(negedge clock);
            check("mst_trdy_timeout", {31'h0, i == WL + 1}, {31'h0, mst_trdy_timeout});
        end
        @(posedge clock);
        #1 mst_wait_trdy = 1'b0;
        @(posedge clock);
        #1 mst_wait_trdy = 1'b1;
        repeat (WL) @(posedge clock);
        #1 mst_trdy = 1'b1;
        @(posedge clock);
        @(negedge clock);
        check("mst_trdy_timeout", 32'h0, {31'h0, mst_trdy_timeout});
        @(posedge clock);
        #1 {mst_wait_trdy, mst_trdy} = 2'b00;
        // Second reset in mid-run with the identity taken from the EPROM
        rst = 1'b1;
        eprom_fitted_pin = 1'b1;
        ew = $random(seed);
        repeat (4) @(posedge clock);
        #1 rst = 1'b0;
        repeat (8) @(posedge clock);
        #1 eprom_id_word = ew;
        eprom_id_valid = 1'b1;
        check("id_loaded", 32'h0, {31'h0, id_loaded});
        @(posedge clock);
        #1 eprom_id_valid = 1'b0;
        check("id_loaded", 32'h1, {31'h0, id_loaded});
        @(posedge clock);
        rd(pch_pkg::OFS_SUBSYS, ew);
        rd(pch_pkg::OFS_MEM_BASE, 32'h0000_0000);
        host.idle(1);
        for (i = 0; i < 10 && exp_q.size() != 0; i++) @(posedge clock);
        check("pending reads", 32'h0, exp_q.size());
        final_report();
    end
endmodule : pch_cfg_header_regs_tb

// ### tb/pch_host_model.sv
// Host bridge model issuing configuration reads and writes
`timescale 1ns/1ps
module pch_host_model (
    // Clock
    input wire logic clock,
    // Configuration access
    output pch_pkg::pch_cfg_req_s cfg_req
);
    initial cfg_req = '0;

    // ------------------------------------------------------------------
    // Access tasks: entered at a rising edge, return at the taking edge
    // ------------------------------------------------------------------
    task automatic access(input logic we, input logic [7:0] addr, input logic [3:0] be,
                          input logic [31:0] wdata);
        #1 cfg_req = {1'b1, we, addr, be, wdata};
        @(posedge clock);
    endtask : access

    // Idle cycles let the bench model a slow host between bursts
    task automatic idle(input int cycles);
        #1 cfg_req = {1'b0, 1'b0, 8'h00, 4'h0, 32'h0};
        repeat (cycles) @(posedge clock);
    endtask : idle
endmodule : pch_host_model

// ### verilog/pch_cfg_header_regs.sv
// Configuration header registers 10h to 40h with window decode and master limits
//
// Functional notes
// - The memory base register is 32-bit read/write and places a 4096-byte window.
// - The I/O window is the 256-byte block whose address bits 31:8 match the programmed I/O base.
// - The memory base reads all zeros after reset.
// - The I/O base reads with only bit 0 set after reset, marking I/O space.
// - Subsystem id (31:16) and vendor id (15:0) are read-only, from EPROM or straps.
// - The capability pointer reads 80h in bits 7:0 and zero above.
// - Maximum latency is a read-only field in bits 31:24 in 250 ns units.
// - Minimum grant is a read-only field in bits 23:16 in 250 ns units.
// - Interrupt pin is a read-only field in bits 15:8 naming pin A.
// - Interrupt line in bits 7:0 is read/write and read back as stored.
// - The latency, grant, pin and line register reads 3E010100h after reset.
// - As master, retries of one transaction stop at the retry limit in bits 15:8.
// - As master, the wait for target ready is at most the clocks in bits 7:0.
`timescale 1ns/1ps
module pch_cfg_header_regs #(
    parameter logic [7:0] RETRY_LIMIT = pch_pkg::RST_RETRY_LIMIT,
    parameter logic [7:0] WAIT_LIMIT = pch_pkg::RST_WAIT_LIMIT
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Configuration access
    input wire pch_pkg::pch_cfg_req_s cfg_req,
    output pch_pkg::pch_cfg_rsp_s cfg_rsp,
    // Address decode
    input wire pch_pkg::pch_bus_addr_s bus_addr,
    input wire logic mem_space_en,
    input wire logic io_space_en,
    output logic mem_hit,
    output logic io_hit,
    // Subsystem identity sources
    input wire logic [31:0] id_strap_pins,
    input wire logic eprom_fitted_pin,
    input wire logic eprom_id_valid,
    input wire logic [31:0] eprom_id_word,
    output logic id_loaded,
    // Master transaction monitor
    input wire logic mst_start,
    input wire logic mst_retry,
    input wire logic mst_wait_trdy,
    input wire logic mst_trdy,
    output logic mst_retry_abort,
    output logic mst_trdy_timeout
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] merge_write(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input logic [3:0] be,
        input logic [31:0] wmask
    );
        logic [31:0] lane_mask;
        lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
        merge_write = (old_val & ~lane_mask) | (new_val & lane_mask);
    endfunction : merge_write

    function automatic logic cfg_write_to(
        input pch_pkg::pch_cfg_req_s r,
        input logic [7:0] ofs
    );
        cfg_write_to = r.req && r.we && (r.addr == ofs);
    endfunction : cfg_write_to

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [31:0] mem_base_reg;
    logic [31:0] io_base_reg;
    logic [31:0] lat_irq_reg;
    logic [31:0] subsys_reg;
    logic [31:0] rd_next;
    logic [31:0] strap_sync;
    logic fitted_sync;
    pch_pkg::pch_id_state_e id_state_reg;
    logic [1:0] settle_cnt_reg;
    logic [7:0] retry_cnt_reg;
    logic [7:0] wait_cnt_reg;
    logic waiting;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    pch_sync2 #(
        .WIDTH(33)
    ) u_pin_sync (
        .clock(clock),
        .rst(rst),
        .din({eprom_fitted_pin, id_strap_pins}),
        .dout({fitted_sync, strap_sync})
    );

    // ------------------------------------------------------------------
    // Writable registers
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            mem_base_reg <= pch_pkg::RST_MEM_BASE;
        end else if (cfg_write_to(cfg_req, pch_pkg::OFS_MEM_BASE)) begin
            mem_base_reg <= merge_write(mem_base_reg, cfg_req.wdata, cfg_req.be,
                                        pch_pkg::WMASK_MEM_BASE);
        end
    end

    // Bit 0 is kept out of the write mask so the space type never changes
    always_ff @(posedge clock) begin
        if (rst) begin
            io_base_reg <= pch_pkg::RST_IO_BASE;
        end else if (cfg_write_to(cfg_req, pch_pkg::OFS_IO_BASE)) begin
            io_base_reg <= merge_write(io_base_reg, cfg_req.wdata, cfg_req.be,
                                       pch_pkg::WMASK_IO_BASE);
        end
    end

    // Only the line byte is writable; latency, grant and pin are fixed
    always_ff @(posedge clock) begin
        if (rst) begin
            lat_irq_reg <= pch_pkg::RST_LAT_IRQ;
        end else if (cfg_write_to(cfg_req, pch_pkg::OFS_LAT_IRQ)) begin
            lat_irq_reg <= merge_write(lat_irq_reg, cfg_req.wdata, cfg_req.be,
                                       pch_pkg::WMASK_LAT_IRQ);
        end
    end

    // ------------------------------------------------------------------
    // Subsystem identity load
    // ------------------------------------------------------------------
    // Straps are sampled a few cycles after release so the synchroniser
    // holds settled pin levels, never the values seen during reset.
    always_ff @(posedge clock) begin
        if (rst) begin
            id_state_reg <= pch_pkg::ID_SETTLE;
            settle_cnt_reg <= 2'h0;
            subsys_reg <= pch_pkg::RST_SUBSYS;
            id_loaded <= 1'b0;
        end else begin
            case (id_state_reg)
                pch_pkg::ID_SETTLE: begin
                    if (settle_cnt_reg == 2'(pch_pkg::STRAP_SETTLE_CYCLES - 1)) begin
                        if (fitted_sync) begin
                            id_state_reg <= pch_pkg::ID_EPROM;
                        end else begin
                            subsys_reg <= strap_sync;
                            id_loaded <= 1'b1;
                            id_state_reg <= pch_pkg::ID_DONE;
                        end
                    end else begin
                        settle_cnt_reg <= settle_cnt_reg + 2'h1;
                    end
                end
                pch_pkg::ID_EPROM: begin
                    if (eprom_id_valid) begin
                        subsys_reg <= eprom_id_word;
                        id_loaded <= 1'b1;
                        id_state_reg <= pch_pkg::ID_DONE;
                    end
                end
                pch_pkg::ID_DONE: begin
                    id_state_reg <= pch_pkg::ID_DONE;
                end
                default: begin
                    id_state_reg <= pch_pkg::ID_SETTLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------
    // Unmapped offsets and reserved bits read zero
    always_comb begin
        rd_next = 32'h0000_0000;
        case (cfg_req.addr)
            pch_pkg::OFS_MEM_BASE: rd_next = mem_base_reg;
            pch_pkg::OFS_IO_BASE: rd_next = io_base_reg;
            pch_pkg::OFS_SUBSYS: rd_next = subsys_reg;
            pch_pkg::OFS_CAP_PTR: rd_next = pch_pkg::RST_CAP_PTR;
            pch_pkg::OFS_LAT_IRQ: rd_next = lat_irq_reg;
            pch_pkg::OFS_LIMITS: rd_next = {16'h0000, RETRY_LIMIT, WAIT_LIMIT};
            default: rd_next = 32'h0000_0000;
        endcase
    end

    // Every access is answered one cycle later; writes answer with zero
    always_ff @(posedge clock) begin
        if (rst) begin
            cfg_rsp <= '0;
        end else begin
            cfg_rsp.ack <= cfg_req.req;
            cfg_rsp.rdata <= (cfg_req.req && !cfg_req.we) ? rd_next : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // Window decode
    // ------------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            mem_hit <= 1'b0;
            io_hit <= 1'b0;
        end else begin
            mem_hit <= bus_addr.valid && mem_space_en &&
                       (bus_addr.addr[31:pch_pkg::MEM_WIN_SHIFT] ==
                        mem_base_reg[31:pch_pkg::MEM_WIN_SHIFT]);
            io_hit <= bus_addr.valid && io_space_en &&
                      (bus_addr.addr[31:pch_pkg::IO_WIN_SHIFT] ==
                       io_base_reg[31:pch_pkg::IO_WIN_SHIFT]);
        end
    end

    // ------------------------------------------------------------------
    // Master retry limit
    // ------------------------------------------------------------------
    // A retry that would exceed the limit is turned into an abort instead
    always_ff @(posedge clock) begin
        if (rst) begin
            retry_cnt_reg <= 8'h00;
            mst_retry_abort <= 1'b0;
        end else begin
            mst_retry_abort <= 1'b0;
            if (mst_start) begin
                retry_cnt_reg <= 8'h00;
            end else if (mst_retry) begin
                if (retry_cnt_reg == RETRY_LIMIT) begin
                    mst_retry_abort <= 1'b1;
                    retry_cnt_reg <= 8'h00;
                end else begin
                    retry_cnt_reg <= retry_cnt_reg + 8'h01;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Master target-ready wait limit
    // ------------------------------------------------------------------
    assign waiting = mst_wait_trdy && !mst_trdy;

    always_ff @(posedge clock) begin
        if (rst) begin
            wait_cnt_reg <= 8'h00;
            mst_trdy_timeout <= 1'b0;
        end else begin
            mst_trdy_timeout <= 1'b0;
            if (!waiting) begin
                wait_cnt_reg <= 8'h00;
            end else if (wait_cnt_reg == WAIT_LIMIT) begin
                mst_trdy_timeout <= 1'b1;
                wait_cnt_reg <= 8'h00;
            end else begin
                wait_cnt_reg <= wait_cnt_reg + 8'h01;
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_mem_base_write: assert property (
        cfg_write_to(cfg_req, pch_pkg::OFS_MEM_BASE) && cfg_req.be == 4'hf
        |=> mem_base_reg == $past(cfg_req.wdata))
        else $error("memory base did not take a full write");

    a_io_window_hit: assert property (
        bus_addr.valid && io_space_en &&
        bus_addr.addr[31:8] == io_base_reg[31:8] && $stable(io_base_reg)
        |=> io_hit)
        else $error("address inside the I/O window was not claimed");

    a_mem_reset_zero: assert property (
        $fell(rst) |-> mem_base_reg == 32'h0000_0000)
        else $error("memory base not zero after reset");

    a_io_type_bit: assert property (
        $fell(rst) |-> io_base_reg == 32'h0000_0001 ##1 io_base_reg[0] [*8])
        else $error("I/O base type bit lost");

    a_subsys_readback: assert property (
        cfg_req.req && !cfg_req.we && cfg_req.addr == pch_pkg::OFS_SUBSYS
        |=> cfg_rsp.ack && cfg_rsp.rdata == $past(subsys_reg))
        else $error("subsystem identity readback wrong");

    a_cap_readback: assert property (
        cfg_req.req && !cfg_req.we && cfg_req.addr == pch_pkg::OFS_CAP_PTR
        |=> cfg_rsp.rdata == 32'h0000_0080)
        else $error("capability pointer readback wrong");

    a_lat_fixed: assert property (
        lat_irq_reg[31:8] == 24'h3e0101)
        else $error("latency grant or pin field changed");

    a_line_write: assert property (
        cfg_write_to(cfg_req, pch_pkg::OFS_LAT_IRQ) && cfg_req.be[0]
        |=> lat_irq_reg[7:0] == $past(cfg_req.wdata[7:0]))
        else $error("interrupt line did not store the written byte");

    // With a zero limit a retry in the abort cycle legally aborts again
    a_retry_abort: assert property (
        mst_retry && !mst_start && retry_cnt_reg == RETRY_LIMIT
        |=> mst_retry_abort && retry_cnt_reg == 8'h00
        ##1 (!mst_retry_abort || $past(mst_retry)))
        else $error("retry limit not enforced");

    a_trdy_timeout: assert property (
        mst_trdy_timeout |-> $past(waiting) && $past(wait_cnt_reg) == WAIT_LIMIT)
        else $error("target ready timeout at the wrong count");

    a_ro_ignored: assert property (
        cfg_write_to(cfg_req, pch_pkg::OFS_SUBSYS) && id_state_reg == pch_pkg::ID_DONE
        |=> $stable(subsys_reg))
        else $error("write changed the subsystem identity");

    a_mem_window_hit: assert property (
        bus_addr.valid && mem_space_en &&
        bus_addr.addr[31:12] == mem_base_reg[31:12]
        |=> mem_hit)
        else $error("address inside the memory window was not claimed");

    a_io_hit_gated: assert property (
        !bus_addr.valid || !io_space_en |=> !io_hit)
        else $error("I/O window claimed while disabled");

    a_io_type_hold: assert property (
        io_base_reg[0])
        else $error("I/O base type bit cleared");

    a_limits_readback: assert property (
        cfg_req.req && !cfg_req.we && cfg_req.addr == pch_pkg::OFS_LIMITS
        |=> cfg_rsp.rdata == {16'h0000, RETRY_LIMIT, WAIT_LIMIT})
        else $error("limit register readback wrong");

    a_retry_count_bound: assert property (
        retry_cnt_reg <= RETRY_LIMIT)
        else $error("retry count passed the limit");

    a_wait_count_bound: assert property (
        wait_cnt_reg <= WAIT_LIMIT)
        else $error("target ready wait count passed the limit");

endmodule : pch_cfg_header_regs

// ### verilog/pch_sync2.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module pch_sync2 #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Data
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] meta_reg;

    // First stage feeds only the second stage
    always_ff @(posedge clock) begin
        if (rst) begin
            meta_reg <= '0;
            dout <= '0;
        end else begin
            meta_reg <= din;
            dout <= meta_reg;
        end
    end

endmodule : pch_sync2
